//--- core/ssf_regs.svh
`ifndef SSF_REGS_SVH
`define SSF_REGS_SVH
// register indices; byte address is four times the index
`define SSF_IDX_ERR_STATE    16'h1a02
`define SSF_IDX_ERR_CODE     16'h1a03
`define SSF_IDX_STATUS_WORD  16'h1a06
`define SSF_IDX_TQ_OFF_ACT   16'h1a10
`define SSF_IDX_TQ_OFF_SEL   16'h1a1a
`define SSF_IDX_ERR_ACT      16'h1a1d
`define SSF_IDX_ACK_REQ      16'h1a1e
`define SSF_IDX_BRK_REL      16'h1a20
`define SSF_IDX_TST_ELAPSED  16'h1a21
`define SSF_IDX_TST_RUN      16'h1a22
`define SSF_IDX_TST_FAIL     16'h1a23
`define SSF_IDX_TST_REQ_BUS  16'h1a61
`define SSF_IDX_TST_INTERVAL 16'h47da
`define SSF_IDX_IRQ_STATUS   16'h1b00
`define SSF_IDX_IRQ_MASK     16'h1b01
// status word bit positions
`define SSF_BIT_TQ_OFF_ACT   0
`define SSF_BIT_TQ_OFF_SEL   10
`define SSF_BIT_ERR_ACT      13
`define SSF_BIT_ACK_REQ      14
`define SSF_BIT_BRK_REL      16
`define SSF_BIT_TST_ELAPSED  17
`define SSF_BIT_TST_RUN      18
`define SSF_BIT_TST_FAIL     19
// interrupt status bit positions
`define SSF_IRQ_TQ_OFF       0
`define SSF_IRQ_ERR          1
`define SSF_IRQ_ELAPSED      2
`define SSF_IRQ_FAIL         3
`define SSF_IRQ_W            4
// timing
`define SSF_CLK_HZ           200000000
`define SSF_TICK_S           1
`define SSF_INTERVAL_RST     32'h00007080
// ahb encodings
`define SSF_HTRANS_NONSEQ    2'h2
`define SSF_HTRANS_SEQ       2'h3
`define SSF_HSIZE_WORD       3'h2
`endif

//--- core/ssf_pkg.sv
package ssf_pkg;
  // safety status flags, grouped as one carrier
  typedef struct packed {
    logic torqueOffActive;
    logic torqueOffSelected;
    logic errorActive;
    logic ackRequired;
    logic brakeReleased;
    logic testElapsed;
    logic testRunning;
    logic testFailed;
  } ssf_flags_s;
  // interval supervision state
  typedef enum logic [1:0] {
    SSF_COUNTING = 2'b01,
    SSF_ELAPSED  = 2'b10
  } ssf_ivl_e;
  typedef logic [7:0] ssf_enum_t;
endpackage : ssf_pkg

//--- core/safety_status_flags.sv
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ssf_regs.svh"
// Overview of operation
// - torque-off active flag, status bit 0
// - three demand sources activate torque-off
// - flag clears when torque-off inactive
// - torque-off selected flag, status bit 10
// - error-active flag follows errors, bit 13
// - acknowledge-required flag, status bit 14
// - brake-released follows brake drive, bit 16
// - interval-elapsed flag after interval, bit 17
// - flag clears only by test; restarts count
// - test-running flag during sequence, bit 18
// - test-failed flag on test error, bit 19
// - eight-bit error state readable
// - eight-bit error code while error present
// - interval counted in seconds, default 8h
// - rising edge of both requests ORed starts test
module safety_status_flags
  import ssf_pkg::*;
#(
  parameter int unsigned CLK_HZ      = `SSF_CLK_HZ,
  parameter logic [31:0] INTERVAL_S  = `SSF_INTERVAL_RST
) (
  // clock and reset
  input  wire  logic        clk,
  input  wire  logic        reset_n,
  // ahb-lite slave
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  // torque-off sources and safety state
  input  wire  logic        stoDemandApp,
  input  wire  logic        stoFaultReaction,
  input  wire  logic        stoDemandBus,
  input  wire  logic        stoInternalRequest,
  input  wire  logic        errorPresent,
  input  wire  logic        ackPending,
  input  wire  logic        brakeDriven,
  input  wire  ssf_enum_t   errorState,
  input  wire  ssf_enum_t   errorCode,
  // brake-test sequencer handshake
  input  wire  logic        testIoRequest,
  input  wire  logic        testSequenceBusy,
  input  wire  logic        testDone,
  input  wire  logic        testFault,
  output logic              testStart,
  // interrupt
  output logic              irq
);

  // one-second tick count, rounded to whole cycles
  localparam int unsigned TICK_CYC = CLK_HZ * `SSF_TICK_S;
  localparam logic [31:0] TICK_MAX = 32'(TICK_CYC - 1);

  // registered flags and enums
  ssf_flags_s  flags_r, flags_nxt;        // mirrored status flags
  ssf_enum_t   errState_r, errState_nxt;  // error state copy
  ssf_enum_t   errCode_r, errCode_nxt;    // error code copy
  // interval supervision
  ssf_ivl_e    ivl_r, ivl_nxt;            // counting or elapsed
  logic [31:0] tick_r, tick_nxt;          // cycle divider
  logic [31:0] secs_r, secs_nxt;          // seconds since last test
  logic [31:0] interval_r, interval_nxt;  // configured interval in s
  // test request edge detection
  logic        busReq_r, busReq_nxt;      // software request level
  logic        reqPrev_r, reqPrev_nxt;    // combined request, delayed
  logic        start_r, start_nxt;        // start pulse to sequencer
  logic        failed_r, failed_nxt;      // sticky test failure
  // interrupt state
  logic [`SSF_IRQ_W-1:0] irqStat_r, irqStat_nxt;
  logic [`SSF_IRQ_W-1:0] irqMask_r, irqMask_nxt;
  logic        irq_r, irq_nxt;
  // bus state
  logic        wrPend_r, wrPend_nxt;      // write data phase follows
  logic [15:0] wrIdx_r, wrIdx_nxt;        // index of pending write
  logic [31:0] rdata_r, rdata_nxt;        // read data for data phase
  // combinational helpers
  logic        accept;                    // valid address phase
  logic [15:0] aIdx;                      // register index of haddr
  logic [31:0] statusWord;                // packed status word
  logic        rdIrq;                     // read of irq status now
  logic [`SSF_IRQ_W-1:0] events;          // rising events this cycle

  assign accept = hsel && hready && (htrans == `SSF_HTRANS_NONSEQ
                  || htrans == `SSF_HTRANS_SEQ);
  assign aIdx   = haddr[17:2];

  // pack mirrors into the status word, other bits read zero
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`SSF_BIT_TQ_OFF_ACT]  = flags_r.torqueOffActive;
    statusWord[`SSF_BIT_TQ_OFF_SEL]  = flags_r.torqueOffSelected;
    statusWord[`SSF_BIT_ERR_ACT]     = flags_r.errorActive;
    statusWord[`SSF_BIT_ACK_REQ]     = flags_r.ackRequired;
    statusWord[`SSF_BIT_BRK_REL]     = flags_r.brakeReleased;
    statusWord[`SSF_BIT_TST_ELAPSED] = flags_r.testElapsed;
    statusWord[`SSF_BIT_TST_RUN]     = flags_r.testRunning;
    statusWord[`SSF_BIT_TST_FAIL]    = flags_r.testFailed;
  end

  // flag capture: all flags are hardware owned, never bus written
  always_comb begin
    flags_nxt = flags_r;
    // any of the three demands removes torque
    flags_nxt.torqueOffActive   = stoDemandApp | stoFaultReaction
                                  | stoDemandBus;
    // any request seen, internal ones included
    flags_nxt.torqueOffSelected = stoDemandApp | stoFaultReaction
                                  | stoDemandBus | stoInternalRequest;
    flags_nxt.errorActive       = errorPresent;
    flags_nxt.ackRequired       = ackPending;
    flags_nxt.brakeReleased     = brakeDriven;
    flags_nxt.testElapsed       = (ivl_r == SSF_ELAPSED);
    flags_nxt.testRunning       = testSequenceBusy | start_r;
    flags_nxt.testFailed        = failed_r;
    errState_nxt = errorState;
    // code only meaningful while an error stands
    errCode_nxt  = errorPresent ? errorCode : 8'h00;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flags_r    <= '0;
      errState_r <= 8'h00;
      errCode_r  <= 8'h00;
    end else begin
      flags_r    <= flags_nxt;
      errState_r <= errState_nxt;
      errCode_r  <= errCode_nxt;
    end
  end

  // brake-test interval supervision in whole seconds
  always_comb begin
    tick_nxt = tick_r;
    secs_nxt = secs_r;
    ivl_nxt  = ivl_r;
    if (testDone) begin
      // a completed test restarts the interval from zero
      tick_nxt = 32'h0000_0000;
      secs_nxt = 32'h0000_0000;
      ivl_nxt  = SSF_COUNTING;
    end else if (tick_r >= TICK_MAX) begin
      tick_nxt = 32'h0000_0000;
      // saturate so a long wait cannot wrap back to counting
      if (secs_r != 32'hffff_ffff) begin
        secs_nxt = secs_r + 32'h0000_0001;
      end
    end else begin
      tick_nxt = tick_r + 32'h0000_0001;
    end
    case (ivl_r)
      SSF_COUNTING: begin
        if (!testDone && secs_r >= interval_r) begin
          ivl_nxt = SSF_ELAPSED;
        end
      end
      SSF_ELAPSED: begin
        // stays elapsed until a test completes
        if (testDone) begin
          ivl_nxt = SSF_COUNTING;
        end
      end
      default: ivl_nxt = SSF_COUNTING;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tick_r <= 32'h0000_0000;
      secs_r <= 32'h0000_0000;
      ivl_r  <= SSF_COUNTING;
    end else begin
      tick_r <= tick_nxt;
      secs_r <= secs_nxt;
      ivl_r  <= ivl_nxt;
    end
  end

  // test start on a rising edge of the two request sources ORed together
  always_comb begin
    reqPrev_nxt = busReq_r | testIoRequest;
    start_nxt   = (busReq_r | testIoRequest) && !reqPrev_r;
    failed_nxt  = failed_r;
    if (start_r) begin
      failed_nxt = 1'b0;                 // new test forgets old result
    end
    if (testFault) begin
      failed_nxt = 1'b1;                 // fault wins over the restart
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reqPrev_r <= 1'b0;
      start_r   <= 1'b0;
      failed_r  <= 1'b0;
    end else begin
      reqPrev_r <= reqPrev_nxt;
      start_r   <= start_nxt;
      failed_r  <= failed_nxt;
    end
  end

  // sticky interrupt events, cleared by a status read
  assign events[`SSF_IRQ_TQ_OFF]  = flags_nxt.torqueOffActive & ~flags_r.torqueOffActive;
  assign events[`SSF_IRQ_ERR]     = flags_nxt.errorActive & ~flags_r.errorActive;
  assign events[`SSF_IRQ_ELAPSED] = flags_nxt.testElapsed & ~flags_r.testElapsed;
  assign events[`SSF_IRQ_FAIL]    = flags_nxt.testFailed & ~flags_r.testFailed;
  assign rdIrq = accept && !hwrite && aIdx == `SSF_IDX_IRQ_STATUS;

  always_comb begin
    // clear first so a same-cycle event still lands
    irqStat_nxt = (rdIrq ? '0 : irqStat_r) | events;
    irq_nxt     = |(irqStat_nxt & irqMask_nxt);
  end

  // bus slave: read data is prepared in the address phase
  always_comb begin
    wrPend_nxt   = accept && hwrite;
    wrIdx_nxt    = aIdx;
    rdata_nxt    = rdata_r;
    busReq_nxt   = busReq_r;
    interval_nxt = interval_r;
    irqMask_nxt  = irqMask_r;
    // data phase of a write; flag registers have no write path
    if (wrPend_r) begin
      case (wrIdx_r)
        `SSF_IDX_TST_REQ_BUS:  busReq_nxt   = hwdata[0];
        `SSF_IDX_TST_INTERVAL: interval_nxt = hwdata;
        `SSF_IDX_IRQ_MASK:     irqMask_nxt  = hwdata[`SSF_IRQ_W-1:0];
        default: ;             // read-only or unmapped: ignored
      endcase
    end
    if (accept && !hwrite) begin
      case (aIdx)
        `SSF_IDX_ERR_STATE:    rdata_nxt = {24'h000000, errState_r};
        `SSF_IDX_ERR_CODE:     rdata_nxt = {24'h000000, errCode_r};
        `SSF_IDX_STATUS_WORD:  rdata_nxt = statusWord;
        `SSF_IDX_TQ_OFF_ACT:   rdata_nxt = {31'h0, flags_r.torqueOffActive};
        `SSF_IDX_TQ_OFF_SEL:   rdata_nxt = {31'h0, flags_r.torqueOffSelected};
        `SSF_IDX_ERR_ACT:      rdata_nxt = {31'h0, flags_r.errorActive};
        `SSF_IDX_ACK_REQ:      rdata_nxt = {31'h0, flags_r.ackRequired};
        `SSF_IDX_BRK_REL:      rdata_nxt = {31'h0, flags_r.brakeReleased};
        `SSF_IDX_TST_ELAPSED:  rdata_nxt = {31'h0, flags_r.testElapsed};
        `SSF_IDX_TST_RUN:      rdata_nxt = {31'h0, flags_r.testRunning};
        `SSF_IDX_TST_FAIL:     rdata_nxt = {31'h0, flags_r.testFailed};
        `SSF_IDX_TST_REQ_BUS:  rdata_nxt = {31'h0, busReq_r};
        `SSF_IDX_TST_INTERVAL: rdata_nxt = interval_r;
        `SSF_IDX_IRQ_STATUS:   rdata_nxt = {28'h0, irqStat_r};
        `SSF_IDX_IRQ_MASK:     rdata_nxt = {28'h0, irqMask_r};
        default:               rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // zero wait states and OKAY always; hsize other than word is
  // accepted as a word access since only word transfers occur
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wrPend_r   <= 1'b0;
      wrIdx_r    <= 16'h0000;
      rdata_r    <= 32'h0000_0000;
      busReq_r   <= 1'b0;
      interval_r <= INTERVAL_S;
      irqMask_r  <= '0;
      irqStat_r  <= '0;
      irq_r      <= 1'b0;
    end else begin
      wrPend_r   <= wrPend_nxt;
      wrIdx_r    <= wrIdx_nxt;
      rdata_r    <= rdata_nxt;
      busReq_r   <= busReq_nxt;
      interval_r <= interval_nxt;
      irqMask_r  <= irqMask_nxt;
      irqStat_r  <= irqStat_nxt;
      irq_r      <= irq_nxt;
    end
  end

  // constant bus handshake, still from flip-flops; ready stays high in
  // reset too, so a master never sees a stall from this slave
  logic readyOut_r;
  logic respOut_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      readyOut_r <= 1'b1;
      respOut_r  <= 1'b0;
    end else begin
      readyOut_r <= 1'b1;
      respOut_r  <= 1'b0;
    end
  end

  assign hreadyout = readyOut_r;
  assign hresp     = respOut_r;
  assign hrdata    = rdata_r;
  assign testStart = start_r;
  assign irq       = irq_r;

endmodule : safety_status_flags

//--- testbench/ssf_checker.sv
`timescale 1ns/1ps
// watches the bus and test-start ports of the status block
module ssf_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // test start
  input wire logic        testIoRequest,
  input wire logic        testStart
);
  // accepted address phases
  wire rdAcc = hsel && hready && htrans[1] && !hwrite;
  wire wrAcc = hsel && hready && htrans[1] && hwrite;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_start_width: assert property (testStart |=> !testStart)
    else $error("start pulse longer than one cycle");
  // a held pin request must not restart the sequencer
  a_start_hold: assert property ($past(testIoRequest) && $past(testIoRequest, 2) |-> !testStart)
    else $error("start pulse on a held request");
  // a pulse needs a fresh pin edge or a recent bus write
  a_start_cause: assert property (testStart |-> ($past(testIoRequest) && !$past(testIoRequest, 2))
    || $past(wrAcc, 2) || $past(wrAcc, 3) || $past(wrAcc, 4))
    else $error("start pulse without a request edge");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave stalled or answered with an error");
  a_rdata_hold: assert property (!$past(rdAcc) |-> $stable(hrdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (rdAcc && haddr == 32'h00000004 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_enum_narrow: assert property (rdAcc && haddr == 32'h00006808 |=> hrdata[31:8] == 24'h0)
    else $error("error state wider than eight bits");
  a_status_spare: assert property (rdAcc && haddr == 32'h00006818 |=> (hrdata & ~32'h000f6401) == 0)
    else $error("status word spare bit set");
endmodule : ssf_checker
bind safety_status_flags ssf_checker ssf_checker_inst (.clk(clk), .reset_n(reset_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .testIoRequest(testIoRequest), .testStart(testStart));

//--- testbench/ssf_bus_master.sv
`timescale 1ns/1ps
`include "ssf_regs.svh"
// stands in for the fieldbus side; single word transfers only
module ssf_bus_master (
  // clock
  input wire logic        clk,
  // slave answer
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // master request
  output logic            hsel,
  output logic [31:0]     haddr,
  output logic [1:0]      htrans,
  output logic            hwrite,
  output logic [2:0]      hsize,
  output logic [31:0]     hwdata
);
  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = `SSF_HSIZE_WORD;
    hwdata = 32'h0;
  end
  // address phase held until hready, then data phase held until hready
  task xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= `SSF_HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    // released lines flip so a stale word never passes for a live one
    haddr <= ~a;
    hwdata <= ~wd;
  endtask : xfer
endmodule : ssf_bus_master

//--- testbench/test_safety_status_flags.sv
`timescale 1ns/1ps
`include "ssf_regs.svh"
module test_safety_status_flags;
  import ssf_pkg::*;
  // bus and design outputs
  logic        clk, reset_n, hsel, hwrite, hreadyout, hresp, testStart, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rv;
  // demand app, fault, bus, internal, error, ack, brake
  logic [6:0]  drv;
  ssf_enum_t   errorState, errorCode;
  logic        testIoRequest, testSequenceBusy, testDone, testFault;
  int          bad_count, checks_done, n;
  // flag register per drive bit and its expected status word
  localparam logic [15:0] FIDX [7] = '{`SSF_IDX_TQ_OFF_ACT, `SSF_IDX_TQ_OFF_ACT,
    `SSF_IDX_TQ_OFF_ACT, `SSF_IDX_TQ_OFF_SEL, `SSF_IDX_ERR_ACT, `SSF_IDX_ACK_REQ, `SSF_IDX_BRK_REL};
  localparam logic [31:0] FSTAT [7] = '{32'h00000401, 32'h00000401, 32'h00000401, 32'h00000400,
    32'h00002000, 32'h00004000, 32'h00010000};
  // short second tick keeps interval runs brief
  safety_status_flags #(.CLK_HZ(10), .INTERVAL_S(32'd1000)) safety_status_flags_inst (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .stoDemandApp(drv[6]), .stoFaultReaction(drv[5]), .stoDemandBus(drv[4]),
    .stoInternalRequest(drv[3]), .errorPresent(drv[2]), .ackPending(drv[1]),
    .brakeDriven(drv[0]), .errorState(errorState), .errorCode(errorCode),
    .testIoRequest(testIoRequest), .testSequenceBusy(testSequenceBusy), .testDone(testDone),
    .testFault(testFault), .testStart(testStart), .irq(irq));
  ssf_bus_master ssf_bus_master_inst (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // byte address is four times the index
  task rdc(input string name, input logic [15:0] idx, input logic [31:0] exp);
    ssf_bus_master_inst.xfer(1'b0, {14'h0, idx, 2'b00}, 32'h0, rv);
    check(name, rv, exp);
  endtask : rdc
  task wrr(input logic [15:0] idx, input logic [31:0] d);
    ssf_bus_master_inst.xfer(1'b1, {14'h0, idx, 2'b00}, d, rv);
  endtask : wrr
  // step off the edge so sampled outputs have settled
  task ticks(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : ticks
  task t_regs;
    rdc("status", `SSF_IDX_STATUS_WORD, 32'h0);
    rdc("interval", `SSF_IDX_TST_INTERVAL, 32'd1000);
    rdc("unmapped", 16'h0001, 32'h0);
    wrr(`SSF_IDX_STATUS_WORD, 32'hffffffff);
    wrr(`SSF_IDX_TQ_OFF_ACT, 32'h1);
    rdc("status ro", `SSF_IDX_STATUS_WORD, 32'h0);
    rdc("flag ro", `SSF_IDX_TQ_OFF_ACT, 32'h0);
  endtask : t_regs
  // each source alone, then released
  task t_flags;
    for (int i = 0; i < 7; i++) begin
      drv <= 7'h40 >> i;
      rdc("flag set", FIDX[i], 32'h1);
      rdc("status set", `SSF_IDX_STATUS_WORD, FSTAT[i]);
      drv <= 7'h0;
      rdc("flag clear", FIDX[i], 32'h0);
    end
  endtask : t_flags
  task t_irq;
    errorState <= 8'h5a;
    errorCode <= 8'hc3;
    rdc("irq events", `SSF_IDX_IRQ_STATUS, 32'h3);
    rdc("irq read clears", `SSF_IDX_IRQ_STATUS, 32'h0);
    wrr(`SSF_IDX_IRQ_MASK, 32'h2);
    drv <= 7'h04;
    rdc("error state", `SSF_IDX_ERR_STATE, 32'h5a);
    rdc("error code", `SSF_IDX_ERR_CODE, 32'hc3);
    check("irq raised", {31'h0, irq}, 32'h1);
    rdc("irq status", `SSF_IDX_IRQ_STATUS, 32'h2);
    ticks(2);
    check("irq dropped", {31'h0, irq}, 32'h0);
    drv <= 7'h0;
    wrr(`SSF_IDX_IRQ_MASK, 32'h0);
    drv <= 7'h04;
    ticks(4);
    check("irq masked", {31'h0, irq}, 32'h0);
    drv <= 7'h0;
    rdc("code no error", `SSF_IDX_ERR_CODE, 32'h0);
  endtask : t_irq
  task t_start;
    @(posedge clk);
    testIoRequest <= 1'b1;
    ticks(1);
    check("pin start", {31'h0, testStart}, 32'h1);
    ticks(1);
    check("held pin", {31'h0, testStart}, 32'h0);
    testSequenceBusy <= 1'b1;
    rdc("running", `SSF_IDX_TST_RUN, 32'h1);
    testFault <= 1'b1;
    ticks(1);
    testFault <= 1'b0;
    rdc("failed", `SSF_IDX_TST_FAIL, 32'h1);
    rdc("status test", `SSF_IDX_STATUS_WORD, 32'h000c0000);
    testIoRequest <= 1'b0;
    testSequenceBusy <= 1'b0;
    wrr(`SSF_IDX_TST_REQ_BUS, 32'h1);
    n = 0;
    repeat (6) begin
      ticks(1);
      n += testStart;
    end
    check("bus start", 32'(n), 32'h1);
    rdc("failed cleared", `SSF_IDX_TST_FAIL, 32'h0);
    wrr(`SSF_IDX_TST_REQ_BUS, 32'h0);
  endtask : t_start
  // interval of three one-second ticks
  task t_ivl;
    testDone <= 1'b1;
    ticks(1);
    testDone <= 1'b0;
    wrr(`SSF_IDX_TST_INTERVAL, 32'd3);
    rdc("elapsed early", `SSF_IDX_TST_ELAPSED, 32'h0);
    ticks(40);
    rdc("elapsed", `SSF_IDX_TST_ELAPSED, 32'h1);
    ticks(20);
    rdc("elapsed kept", `SSF_IDX_TST_ELAPSED, 32'h1);
    testDone <= 1'b1;
    ticks(1);
    testDone <= 1'b0;
    rdc("elapsed cleared", `SSF_IDX_TST_ELAPSED, 32'h0);
    ticks(5);
    rdc("count restarted", `SSF_IDX_TST_ELAPSED, 32'h0);
  endtask : t_ivl
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #100us;
    bad_count++;
    finish_test;
  end
  initial begin
    reset_n = 1'b0;
    drv = 7'h0;
    errorState = 8'h00;
    errorCode = 8'h00;
    testIoRequest = 1'b0;
    testSequenceBusy = 1'b0;
    testDone = 1'b0;
    testFault = 1'b0;
    bad_count = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_regs;
    t_flags;
    t_irq;
    t_start;
    t_ivl;
    finish_test;
  end
endmodule : test_safety_status_flags
